// *** bsr_pkg.sv ***
// Shared constants and types for the four-beat burst SRAM port model.
// Assumes one 200 MHz system clock, each cycle standing for one input
// clock phase of the memory (positive and negative rises alternate).
`default_nettype none
package bsr_pkg;
	// Organisation defaults
	localparam int BSR_DATA_W = 18;
	localparam int BSR_ADDR_W = 8;
	localparam int BSR_LANE_W = 9;
	localparam int BSR_BURST_LEN = 4;
	localparam int BSR_BEAT_W = 2;
	// Data buffer depth between the write port and the array
	localparam int BSR_FIFO_DEPTH = 32;
	// Pipeline stage (edges after the start) of the first beat
	localparam int BSR_WR_FIRST = 1;
	localparam int BSR_RD_FIRST = 4;
	localparam int BSR_RD_STAGES = BSR_RD_FIRST + BSR_BURST_LEN;
	localparam int BSR_WR_STAGES = BSR_WR_FIRST + BSR_BURST_LEN;
	// System clock period and the input clock period it represents
	localparam int BSR_CLK_PERIOD_NS = 5;
	localparam int BSR_PHASES_PER_CYCLE = 2;
	// Values after reset
	localparam logic BSR_SEL_RST = 1'h1;
	localparam logic BSR_OE_RST = 1'h0;
	// Input clock phase that the next edge stands for
	typedef enum logic {
		BSR_PH_POS = 1'b0,
		BSR_PH_NEG = 1'b1
	} bsr_phase_t;
endpackage
`default_nettype wire

// *** bsr_port.sv ***
// Burst SRAM with separate read and write ports on one address bus.
// Assumes a memory controller on the pins, sampled through two flops,
// that aligns its operations to the phase flag driven out here.
// Read data leaves two edges later than the pin timing suggests,
// because every pin passes two synchronising flops first.
// Memory contents are not reset; unwritten words read as unknown.
//
// Function
// R01: Write address at positive rise t; four data beats at t+1, t+2.
// R02: Read address at rise t; words appear t+2 negative through t+4.
// R03: Burst walks A, A+1, A+2, A+3, one location per beat.
// R04: After reset the device is deselected with read outputs floating.
// R05: Write data taken and read data launched on both phases.
// R06: Controller should park both clock phases high when stopping.
// R07: Select that started an operation is ignored on the next rise.
// R08: Second read or write on consecutive rises is discarded.
// R09: Narrow width: two active-low lane selects gate bits 8:0, 17:9.
// R10: Narrow width: both lanes deselected leaves the location unchanged.
// R11: Wide width: four lane selects gate nine-bit lanes; others kept.
// R12: Wide width: all lanes selected store the whole word.
// R13: Wide width: all lanes deselected write nothing.
// R14: Lane selects sampled every beat and applied independently.
// R15: Both selects active from idle alternate, read first.
// R16: No select means no operation; stopped clock holds state.
`timescale 1ns/10ps
`default_nettype none

// Synchronous FIFO with registered full and empty flags
module bsr_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Filling side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Draining side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);
	localparam logic [PW:0] FULL_CNT = (PW+1)'(DEPTH);

	logic [WIDTH-1:0] store [0:DEPTH-1];
	logic [PW-1:0] wr_ptr_q;
	logic [PW-1:0] rd_ptr_q;
	logic [PW:0] count_q;
	logic [PW:0] count_d;
	logic full_q;
	logic empty_q;
	logic ready_q;
	wire push = in_valid & ~full_q;
	wire pop = out_ready & ~empty_q;

	initial begin
		if (DEPTH < 2 || (1 << PW) != DEPTH)
			$error("bsr_fifo: DEPTH must be a power of two");
		if (WIDTH < 1)
			$error("bsr_fifo: WIDTH must be positive");
	end

	// Occupancy after this edge
	assign count_d = count_q + (PW+1)'(push) - (PW+1)'(pop);
	// Ready is a flop of its own so the top can pass it straight out
	assign in_ready = ready_q;
	assign out_valid = ~empty_q;
	assign out_data = store[rd_ptr_q];

	// Storage write, no reset on data
	always_ff @(posedge clock) begin
		if (push)
			store[wr_ptr_q] <= in_data;
	end

	// Pointers and flags
	// Flags follow the next count, so they never lag a push or pop
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
			full_q <= 1'h0;
			empty_q <= 1'h1;
			ready_q <= 1'h1;
		end else begin
			wr_ptr_q <= wr_ptr_q + PW'(push);
			rd_ptr_q <= rd_ptr_q + PW'(pop);
			count_q <= count_d;
			full_q <= (count_d == FULL_CNT);
			empty_q <= (count_d == '0);
			ready_q <= (count_d != FULL_CNT);
		end
	end
endmodule

// Device top: port logic, burst pipelines and the storage array
module bsr_port import bsr_pkg::*; #(
	parameter int DATA_W = BSR_DATA_W,
	parameter int ADDR_W = BSR_ADDR_W,
	parameter int FIFO_DEPTH = BSR_FIFO_DEPTH
) (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Control pins
	input wire logic read_port_select_n,
	input wire logic write_port_select_n,
	input wire logic [ADDR_W-1:0] addr,
	// Write port pins
	input wire logic [DATA_W/BSR_LANE_W-1:0] byte_write_select_n,
	input wire logic [DATA_W-1:0] wr_data,
	// Read port pins, enable high while driving
	output logic [DATA_W-1:0] rd_data,
	output logic rd_data_oe,
	// Phase of the next sampling edge, 0 for a positive rise
	output logic neg_phase,
	// Low while the write buffer is full and beats would be lost
	output logic wr_buf_ready
);
	localparam int LANES = DATA_W / BSR_LANE_W;
	localparam int MA_W = ADDR_W + BSR_BEAT_W;
	localparam int ENT_W = MA_W + 2 * DATA_W;

	// Storage array, four words per burst address
	// Written only by the buffer drain, read by read beats and by the drain's lane merge
	logic [DATA_W-1:0] mem [0:(1 << MA_W)-1];

	// Pin synchronisers
	// All pin copies share one delay, so relative timing is kept
	logic rps_s1_q, rps_s2_q, wps_s1_q, wps_s2_q;
	logic [ADDR_W-1:0] addr_s1_q, addr_s2_q;
	logic [LANES-1:0] bws_s1_q, bws_s2_q;
	logic [DATA_W-1:0] wd_s1_q, wd_s2_q;

	// Phase, start history and burst pipelines
	// Stage i of a shift holds the start made i edges ago
	bsr_phase_t phase_q;
	logic last_rd_q, last_wr_q;
	logic [BSR_RD_STAGES-1:0] rv_q;
	logic [ADDR_W-1:0] ra_q [0:BSR_RD_STAGES-1];
	logic [BSR_WR_STAGES-1:0] wv_q;
	logic [ADDR_W-1:0] wa_q [0:BSR_WR_STAGES-1];
	logic [DATA_W-1:0] rd_data_q;
	logic rd_oe_q;

	// Buffer and beat selection
	logic rd_beat, wr_beat;
	logic [MA_W-1:0] rd_word, wr_word;
	logic [ENT_W-1:0] fifo_in, fifo_out;
	logic fifo_ready, fifo_valid, drain;
	logic [MA_W-1:0] dr_addr;
	logic [DATA_W-1:0] dr_mask, dr_data;

	// Refuse organisations the lane logic cannot serve
	initial begin
		if (DATA_W != 18 && DATA_W != 36)
			$error("bsr_port: DATA_W must be 18 or 36");
		if (DATA_W % BSR_LANE_W != 0)
			$error("bsr_port: DATA_W must be whole lanes");
		if (ADDR_W < 1)
			$error("bsr_port: ADDR_W must be at least 1");
		if (FIFO_DEPTH < 2)
			$error("bsr_port: FIFO_DEPTH must be at least 2");
		if (BSR_BURST_LEN != (1 << BSR_BEAT_W))
			$error("bsr_port: burst length must fill the beat field");
	end

	// Expand active-low lane selects to a bit mask
	// Lane i covers nine bits starting at bit 9i
	function automatic logic [DATA_W-1:0] lane_mask(
		input logic [LANES-1:0] sel_n
	);
		logic [DATA_W-1:0] m;
		m = '0;
		for (int i = 0; i < LANES; i++)
			m[i*BSR_LANE_W +: BSR_LANE_W] = {BSR_LANE_W{~sel_n[i]}};
		return m;
	endfunction

	// Two flops on every pin before any logic looks at it
	// Resetting to deselected keeps an idle pin from starting a burst
	// Data and selects share the delay so beats stay aligned
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			rps_s1_q <= BSR_SEL_RST;
			rps_s2_q <= BSR_SEL_RST;
			wps_s1_q <= BSR_SEL_RST;
			wps_s2_q <= BSR_SEL_RST;
			addr_s1_q <= '0;
			addr_s2_q <= '0;
			bws_s1_q <= '1;
			bws_s2_q <= '1;
			wd_s1_q <= '0;
			wd_s2_q <= '0;
		end else begin
			rps_s1_q <= read_port_select_n;
			rps_s2_q <= rps_s1_q;
			wps_s1_q <= write_port_select_n;
			wps_s2_q <= wps_s1_q;
			addr_s1_q <= addr;
			addr_s2_q <= addr_s1_q;
			bws_s1_q <= byte_write_select_n;
			bws_s2_q <= bws_s1_q;
			wd_s1_q <= wr_data;
			wd_s2_q <= wd_s1_q;
		end
	end

	// Pins reach the decode two edges late; the phase flag is aligned
	// so a pin sample taken at a positive rise is decoded on one too
	// Start decode on positive rises only
	wire pos_rise = (phase_q == BSR_PH_POS);
	// R07 R08: ignore repeat
	wire rd_ok = pos_rise & ~rps_s2_q & ~last_rd_q;
	wire wr_ok = pos_rise & ~wps_s2_q & ~last_wr_q;
	// R15: read wins from idle
	wire start_rd = rd_ok;
	// Write starts only when no read starts on this rise
	wire start_wr = wr_ok & ~rd_ok;

	// Phase and start history; R16 no select, no start
	// History is one positive rise deep
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			phase_q <= BSR_PH_POS;
			last_rd_q <= 1'h0;
			last_wr_q <= 1'h0;
		end else begin
			phase_q <= (phase_q == BSR_PH_POS) ? BSR_PH_NEG : BSR_PH_POS;
			if (pos_rise) begin
				last_rd_q <= start_rd;
				last_wr_q <= start_wr;
			end
		end
	end

	// R01 R02: stage valid shifts
	// A start walks down the shift; fixed taps pick its beats
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			rv_q <= '0;
			wv_q <= '0;
		end else begin
			rv_q <= {rv_q[BSR_RD_STAGES-2:0], start_rd};
			wv_q <= {wv_q[BSR_WR_STAGES-2:0], start_wr};
		end
	end

	// Address pipelines follow the valid shifts
	// No reset: addresses only matter where a valid bit travels
	always_ff @(posedge clock) begin
		ra_q[0] <= addr_s2_q;
		wa_q[0] <= addr_s2_q;
		for (int i = 1; i < BSR_RD_STAGES; i++)
			ra_q[i] <= ra_q[i-1];
		for (int i = 1; i < BSR_WR_STAGES; i++)
			wa_q[i] <= wa_q[i-1];
	end

	// R03: beat picks word A+k
	// Starts of one kind are at least four edges apart, so one tap is live
	// Tap k of each shift carries beat k of its burst
	always_comb begin
		rd_beat = 1'h0;
		wr_beat = 1'h0;
		rd_word = '0;
		wr_word = '0;
		for (int k = 0; k < BSR_BURST_LEN; k++) begin
			if (rv_q[BSR_RD_FIRST+k]) begin
				rd_beat = 1'h1;
				rd_word = {ra_q[BSR_RD_FIRST+k], BSR_BEAT_W'(k)};
			end
			if (wv_q[BSR_WR_FIRST+k]) begin
				wr_beat = 1'h1;
				wr_word = {wa_q[BSR_WR_FIRST+k], BSR_BEAT_W'(k)};
			end
		end
	end

	// R05 R14: every phase, own mask
	assign fifo_in = {wr_word, lane_mask(bws_s2_q), wd_s2_q};
	// R10 R13: empty mask not stored
	wire lanes_off = (bws_s2_q == '1);
	wire push_beat = wr_beat & ~lanes_off;

	// Beats are buffered so a read beat costs no write beat unless the buffer is full
	// Entry layout: word address, lane mask, data
	// A full buffer drops beats; the ready output shows it

	bsr_fifo #(
		.WIDTH(ENT_W),
		.DEPTH(FIFO_DEPTH)
	) bsr_fifo_inst (
		.clock(clock),
		.sys_rst(sys_rst),
		.in_valid(push_beat),
		.in_ready(fifo_ready),
		.in_data(fifo_in),
		.out_valid(fifo_valid),
		.out_ready(drain),
		.out_data(fifo_out)
	);

	// Array has one port: a read beat stalls the drain
	// Reads win: their timing is fixed, while drained writes can wait
	assign drain = fifo_valid & ~rd_beat;
	assign dr_addr = fifo_out[ENT_W-1 -: MA_W];
	assign dr_mask = fifo_out[2*DATA_W-1 -: DATA_W];
	assign dr_data = fifo_out[DATA_W-1:0];

	// R09 R11 R12: lane merge
	// Lanes whose select is high keep their stored bits
	always_ff @(posedge clock) begin
		if (drain)
			mem[dr_addr] <= (mem[dr_addr] & ~dr_mask) | (dr_data & dr_mask);
	end

	// R02 R05: launch each phase
	// Data holds between bursts; the enable says when it counts
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			rd_data_q <= '0;
			// R04: outputs float
			rd_oe_q <= BSR_OE_RST;
		end else begin
			// R16: float after bursts
			rd_oe_q <= rd_beat;
			if (rd_beat)
				rd_data_q <= mem[rd_word];
		end
	end

	// Outputs straight from flops
	// Buffer ready comes from the flop inside the buffer
	assign rd_data = rd_data_q;
	assign rd_data_oe = rd_oe_q;
	assign neg_phase = phase_q;
	assign wr_buf_ready = fifo_ready;
endmodule
`default_nettype wire

// *** bsr_port_assertions.sv ***
// Checker for the burst SRAM port: read timing and select handling.
// Assumes it is bound to the device top and sees its pins only.
`timescale 1ns/10ps
`default_nettype none
module bsr_port_chk (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Pins watched
	input wire logic read_port_select_n,
	input wire logic write_port_select_n,
	input wire logic rd_data_oe,
	input wire logic neg_phase
);
	logic rd_req;
	logic [3:0] idle_q;
	logic [3:0] idle_d;
	// Read request at a positive rise; edges since the last read select
	assign rd_req = !read_port_select_n && !neg_phase;
	assign idle_d = read_port_select_n ?
		idle_q + {3'h0, idle_q != 4'hF} : 4'h0;
	// Idle edge counter
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			idle_q <= 4'h0;
		end else begin
			idle_q <= idle_d;
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	sequence s_quiet; read_port_select_n && !neg_phase; endsequence
	sequence s_dbl; !read_port_select_n ##2 !read_port_select_n; endsequence
	sequence s_four; rd_data_oe [*4]; endsequence
	property p_oe_lat; $rose(rd_data_oe) |-> $past(rd_req, 8); endproperty
	property p_oe_ph; $rose(rd_data_oe) |-> !neg_phase; endproperty
	property p_burst; $rose(rd_data_oe) |-> s_four; endproperty
	property p_rst; $past(sys_rst) |-> !rd_data_oe; endproperty
	property p_phase; !$past(sys_rst) |-> neg_phase != $past(neg_phase);
	endproperty
	property p_drop; s_quiet ##2 s_dbl ##2 read_port_select_n
		|-> ##8 !rd_data_oe; endproperty
	property p_both; (s_quiet and write_port_select_n) ##2
		(!read_port_select_n && !write_port_select_n) |-> ##8 rd_data_oe;
	endproperty
	property p_idle; idle_q >= 4'hB |-> !rd_data_oe; endproperty
	a_oe_lat: assert property (p_oe_lat) else $error("read late");
	a_oe_ph: assert property (p_oe_ph) else $error("read phase");
	a_burst: assert property (p_burst) else $error("burst short");
	a_rst: assert property (p_rst) else $error("driven at reset");
	a_phase: assert property (p_phase) else $error("phase stuck");
	a_drop: assert property (p_drop) else $error("read kept");
	a_both: assert property (p_both) else $error("no read first");
	a_idle: assert property (p_idle) else $error("bus not idle");
endmodule
bind bsr_port bsr_port_chk bsr_port_chk_inst (.clock(clock),
	.sys_rst(sys_rst), .read_port_select_n(read_port_select_n),
	.write_port_select_n(write_port_select_n),
	.rd_data_oe(rd_data_oe), .neg_phase(neg_phase));
`default_nettype wire

// *** bsr_ctl_model.sv ***
// Memory controller model driving the pins of the burst SRAM port.
// Assumes the bench calls its tasks; pins change at falling edges.
`timescale 1ns/10ps
`default_nettype none
module bsr_ctl_model (
	// Clock and phase flag
	input wire logic clock,
	input wire logic neg_phase,
	// Controller pins
	output logic read_port_select_n,
	output logic write_port_select_n,
	output logic [7:0] addr,
	output logic [1:0] byte_write_select_n,
	output logic [17:0] wr_data
);
	// Idle pins at time zero
	// pins park idle between bursts; the clock here runs free
	initial begin
		read_port_select_n = 1'h1;
		write_port_select_n = 1'h1;
		addr = 8'h00;
		byte_write_select_n = 2'h3;
		wr_data = 18'h00000;
	end
	// selects for one positive rise only
	task automatic start(input logic rn, input logic wn,
		input logic [7:0] a);
		@(negedge clock);
		while (neg_phase !== 1'h0) @(negedge clock);
		read_port_select_n <= rn;
		write_port_select_n <= wn;
		addr <= a;
		@(negedge clock);
		read_port_select_n <= 1'h1;
		write_port_select_n <= 1'h1;
		addr <= ~a;
	endtask
	task automatic beats(input logic [71:0] d, input logic [7:0] m);
		for (int k = 0; k < 4; k++) begin
			@(negedge clock);
			wr_data <= d[18*k +: 18];
			byte_write_select_n <= m[2*k +: 2];
		end
		@(negedge clock);
		wr_data <= ~d[71:54];
		byte_write_select_n <= 2'h3;
	endtask
endmodule
`default_nettype wire

// *** bsr_port_tb.sv ***
// Self-checking bench for the burst SRAM port with a controller model.
// Assumes the default 18-bit organisation and an 8-bit burst address.
`timescale 1ns/10ps
`default_nettype none
module bsr_port_tb;
	logic clock = 1'h0;
	logic sys_rst = 1'h1;
	wire rsel_n, wsel_n, oe, ph, rdy;
	wire [7:0] addr;
	wire [1:0] lane_n;
	wire [17:0] wd, rd;
	int fail_count = 0;
	int total_checks = 0;
	logic [17:0] mem [1024];
	logic [17:0] expq [$];
	logic [71:0] d;
	// Clock, 5 ns period
	always #2.5 clock = ~clock;
	// Device and controller
	bsr_port bsr_port_inst (.clock(clock), .sys_rst(sys_rst),
		.read_port_select_n(rsel_n), .write_port_select_n(wsel_n),
		.addr(addr), .byte_write_select_n(lane_n), .wr_data(wd),
		.rd_data(rd), .rd_data_oe(oe), .neg_phase(ph),
		.wr_buf_ready(rdy));
	bsr_ctl_model bsr_ctl_model_inst (.clock(clock), .neg_phase(ph),
		.read_port_select_n(rsel_n), .write_port_select_n(wsel_n),
		.addr(addr), .byte_write_select_n(lane_n), .wr_data(wd));
	task automatic check(input string n, input logic [17:0] e, s);
		total_checks++;
		if (s !== e) begin
			fail_count++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask
	// Write a burst, mirroring only the selected lanes
	task automatic wr(input logic [7:0] a, input logic [71:0] v,
		input logic [7:0] m);
		for (int k = 0; k < 8; k++)
			if (!m[k]) mem[{a, 2'(k/2)}][9*(k%2) +: 9] = v[9*k +: 9];
		bsr_ctl_model_inst.start(1'h1, 1'h0, a);
		bsr_ctl_model_inst.beats(v, m);
	endtask
	// Note a burst's words, then issue the read
	task automatic rd_op(input logic [7:0] a, input logic wn);
		for (int k = 0; k < 4; k++) expq.push_back(mem[{a, 2'(k)}]);
		bsr_ctl_model_inst.start(1'h0, wn, a);
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Take the oldest note for every driven read beat
	always @(negedge clock) begin
		if (oe === 1'h1 && expq.size() == 0) begin
			fail_count++;
			$display("[ERR] rd_data exp none got %h", rd);
		end else if (oe === 1'h1) begin
			check("rd_data", expq.pop_front(), rd);
		end
	end
	// Watchdog
	initial begin
		#20000;
		fail_count++;
		$display("[ERR] watchdog exp done got hang");
		close_out();
	end
	initial begin
		void'($urandom(2830));
		repeat (3) @(posedge clock);
		@(negedge clock);
		sys_rst = 1'h0;
		check("rd_data_oe", 18'h0, {17'h0, oe});
		check("wr_buf_ready", 18'h1, {17'h0, rdy});
		$display("reset test done");
		for (int i = 0; i < 4; i++) begin
			d = 72'({$urandom(), $urandom(), $urandom()});
			wr(8'(i * 37), d, 8'h00);
		end
		repeat (20) @(negedge clock);
		for (int i = 0; i < 4; i++) begin
			rd_op(8'(i * 37), 1'h1);
			repeat (2) @(negedge clock);
		end
		$display("burst test done");
		d = 72'({$urandom(), $urandom(), $urandom()});
		wr(8'h00, d, 8'hE4);
		repeat (20) @(negedge clock);
		rd_op(8'h00, 1'h1);
		repeat (2) @(negedge clock);
		$display("lane test done");
		rd_op(8'h25, 1'h1);
		bsr_ctl_model_inst.start(1'h0, 1'h1, 8'h4A);
		repeat (2) @(negedge clock);
		rd_op(8'h6F, 1'h0);
		repeat (20) @(negedge clock);
		// Second write on the next rise must be dropped
		while (ph !== 1'h1) @(negedge clock);
		d = 72'({$urandom(), $urandom(), $urandom()});
		fork
			wr(8'h6F, d, 8'h00);
			begin
				repeat (2) @(negedge clock);
				bsr_ctl_model_inst.start(1'h1, 1'h0, 8'h4A);
			end
		join
		repeat (20) @(negedge clock);
		rd_op(8'h6F, 1'h1);
		repeat (2) @(negedge clock);
		rd_op(8'h4A, 1'h1);
		repeat (20) @(negedge clock);
		check("wr_buf_ready", 18'h1, {17'h0, rdy});
		check("pending", 18'h0, 18'(expq.size()));
		$display("select test done");
		close_out();
	end
endmodule
`default_nettype wire
